// >>> pkg/sync_mode_pkg.sv
// Shared constants and carriers for the timing synchronizer mode control.
// Assumes a 40 MHz core clock and a byte-addressed register port with 8-bit address and 32-bit data.
package sync_mode_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int LOCK_TIME_S = 25;
  localparam int LOCK_CYCLES = LOCK_TIME_S * CLK_HZ;
  localparam int STORE_TIME_MS = 30;
  localparam int STORE_CYCLES = STORE_TIME_MS * (CLK_HZ / 1000);
  localparam int FREQ_W = 24;
  localparam int PIN_W = 10;
  localparam int EVT_W = 5;

  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CLEAR = 8'h04;
  localparam logic [7:0] ADDR_ENABLE = 8'h08;
  localparam logic [7:0] ADDR_STATE = 8'h0c;
  localparam logic [7:0] ADDR_CTRL = 8'h10;

  localparam int EVT_CHANGE = 0;
  localparam int EVT_AUTO_IN = 1;
  localparam int EVT_AUTO_OUT = 2;
  localparam int EVT_LOCK_LATE = 3;
  localparam int EVT_BAD_PINS = 4;

  localparam logic [EVT_W-1:0] ENABLE_RST = 5'h00;
  localparam logic CTRL_MON_RST = 1'b1;

  localparam int STATE_FSM_POS = 0;
  localparam int STATE_SEC_POS = 3;
  localparam int STATE_CORR_POS = 4;
  localparam int STATE_MODE_POS = 5;
  localparam int STATE_FSEL_POS = 7;
  localparam int STATE_LOCK_POS = 9;

  localparam logic [1:0] MS_NORMAL = 2'h0;
  localparam logic [1:0] MS_HOLD = 2'h1;
  localparam logic [1:0] MS_FREE = 2'h2;
  localparam logic [1:0] MS_AUTO = 2'h3;
  localparam logic [1:0] FS_RESERVED = 2'h0;

  typedef enum logic [1:0] {DPLL_NORMAL, DPLL_HOLDOVER, DPLL_FREERUN} dpll_mode_t;

  typedef struct packed {
    logic frame_pulse_8k_out;
    logic ref_impaired;
    logic primary_loss_in;
    logic secondary_loss_in;
    logic guard_time_in;
    logic mode_sel_high;
    logic mode_sel_low;
    logic ref_select_in;
    logic freq_sel_high;
    logic freq_sel_low;
  } ctrl_pins_t;

  typedef struct packed {
    logic use_secondary_reference;
    logic phase_step_corrector_en;
    logic corrector_realign;
    dpll_mode_t mode;
  } loop_ctrl_t;
endpackage : sync_mode_pkg

// >>> rtl/input_sync.sv
// Two-stage synchronizer for a bundle of asynchronous pins.
// Assumes the pins change slowly against the core clock.
`timescale 1ns/1ps
`default_nettype none
module input_sync #(
  parameter int W = 10
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_t;

  sync_state_t s_q, s_d;

  if (W < 1) begin : g_bad_width
    $error("input_sync width must be positive");
  end

  always_comb begin
    s_d.s1 = d_in;
    s_d.s2 = s_q.s1;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign q_out = s_q.s2;
endmodule : input_sync
`default_nettype wire

// >>> rtl/holdover_store.sv
// Two-slot frequency store that feeds the oscillator in holdover.
// Assumes the frequency word and strobes share the core clock.
`timescale 1ns/1ps
`default_nettype none
module holdover_store #(
  parameter int FW = 24,
  parameter int PERIOD = 1_200_000
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic store_en,
  input wire logic load,
  input wire logic [FW-1:0] freq_in,
  output logic [FW-1:0] hold_freq
);
  localparam int CW = $clog2(PERIOD + 1);

  typedef struct packed {
    logic [1:0][FW-1:0] slot;
    logic [1:0] valid;
    logic next_slot;
    logic [CW-1:0] cnt;
    logic [FW-1:0] hold;
  } store_state_t;

  store_state_t s_q, s_d;

  if (PERIOD < 2 || FW < 1) begin : g_bad_param
    $error("holdover_store needs PERIOD of 2 or more");
  end

  always_comb begin
    s_d = s_q;
    if (!store_en) begin
      s_d.cnt = '0;
    end else if (s_q.cnt == CW'(PERIOD - 1)) begin
      // Alternate slots so the other one is always one period older
      s_d.cnt = '0;
      s_d.slot[s_q.next_slot] = freq_in;
      s_d.valid[s_q.next_slot] = 1'b1;
      s_d.next_slot = ~s_q.next_slot;
    end else begin
      s_d.cnt = s_q.cnt + CW'(1);
    end
    // Older slot is the next write target, never the latest sample
    if (load && s_q.valid[s_q.next_slot]) begin
      s_d.hold = s_q.slot[s_q.next_slot];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign hold_freq = s_q.hold;
endmodule : holdover_store
`default_nettype wire

// >>> rtl/sync_mode_control_fsm.sv
// Mode and reference control for the timing synchronizer loop.
// Assumes pins arrive asynchronously; lock flag and frequency word share
// the core clock with this block.
//
// How it works
// - Selected reference impaired in Normal: enter auto-holdover at once.
// - Reference valid again: leave auto-holdover back to Normal, same reference.
// - Auto-holdover entry and exit never engage the phase-step corrector.
// - Every state change happens on a frame pulse rising edge.
// - Machine drives reference select, corrector enable, corrector realign, loop mode.
// - Primary holdover to primary normal: corrector on if guard 1, off if 0.
// - Auto, primary normal: guard 0 goes primary holdover, 1 secondary normal.
// - Mode pins: 00 normal, 01 holdover, 10 freerun, 11 automatic.
// - Manual: reference pin picks primary/secondary; auto: 1 is reserved.
// - Automatic control picks mode and reference from loss and guard pins.
// - After reset the loop must lock within 25 seconds.
// - In locked Normal, store frequency every 30 ms in alternating slots.
// - Holdover takes the stored value 30 to 60 ms old.
// - Frequency pins pick 8 kHz, 1.544 MHz or 2.048 MHz reference.
// - Freerun runs from the master clock and ignores both references.
// - Reference switch: holdover first, realign corrector, then Normal.
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module sync_mode_control_fsm #(
  parameter int LOCK_CYCLES = sync_mode_pkg::LOCK_CYCLES,
  parameter int STORE_CYCLES = sync_mode_pkg::STORE_CYCLES,
  parameter int FREQ_W = sync_mode_pkg::FREQ_W
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire sync_mode_pkg::ctrl_pins_t pins,
  input wire logic dpll_locked,
  input wire logic [FREQ_W-1:0] dpll_freq,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output sync_mode_pkg::loop_ctrl_t loop_ctrl,
  output logic [1:0] freq_sel,
  output logic [FREQ_W-1:0] holdover_freq,
  output logic irq
);
  localparam int LCW = 30;
  localparam int EW = sync_mode_pkg::EVT_W;

  typedef enum logic [2:0] {
    ST_FREE, ST_NORM, ST_HOLD, ST_AUTO_HOLD, ST_REALIGN
  } fsm_t;

  typedef struct packed {
    fsm_t st;
    logic ref_sec;
    logic corr_en;
    sync_mode_pkg::loop_ctrl_t ctl;
    logic [1:0] fsel;
    logic fp_prev;
    logic mon_en;
    logic [EW-1:0] status;
    logic [EW-1:0] enable;
    logic [31:0] rdata;
    logic [LCW-1:0] lock_cnt;
    logic lock_done;
  } ctl_state_t;

  ctl_state_t s_q, s_d;
  sync_mode_pkg::ctrl_pins_t p;
  logic tick;
  logic [1:0] ms;
  logic hold_load;
  logic [EW-1:0] evt;
  logic [EW-1:0] clr;

  if (LOCK_CYCLES < 2 || LOCK_CYCLES >= 2 ** LCW) begin : g_bad_lock
    $error("LOCK_CYCLES out of range for the lock timer");
  end

  // All control pins pass two flops before use
  input_sync #(
    .W(sync_mode_pkg::PIN_W)
  ) u_pin_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .ce(ce),
    .d_in(pins),
    .q_out(p)
  );

  holdover_store #(
    .FW(FREQ_W),
    .PERIOD(STORE_CYCLES)
  ) u_store (
    .core_clk(core_clk),
    .nrst(nrst),
    .ce(ce),
    .store_en(s_q.st == ST_NORM && dpll_locked),
    .load(hold_load),
    .freq_in(dpll_freq),
    .hold_freq(holdover_freq)
  );

  // Corrector is needed on any entry to Normal except primary hold to
  // primary normal with guard low, or a move out of freerun.
  function automatic logic needs_align(fsm_t st, logic cur_sec,
                                       logic tgt_sec, logic gt);
    logic r;
    r = 1'b0;
    case (st)
      ST_NORM: r = cur_sec != tgt_sec;
      ST_HOLD, ST_AUTO_HOLD: r = cur_sec || tgt_sec || gt;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : needs_align

  function automatic logic is_hold(fsm_t st);
    return st == ST_HOLD || st == ST_AUTO_HOLD || st == ST_REALIGN;
  endfunction : is_hold

  always_comb begin
    logic go_free;
    logic go_hold;
    logic go_norm;
    logic tgt;
    go_free = 1'b0;
    go_hold = 1'b0;
    go_norm = 1'b0;
    tgt = s_q.ref_sec;
    s_d = s_q;
    evt = '0;
    ms = {p.mode_sel_high, p.mode_sel_low};
    // Frame pulse rising edge paces the machine
    tick = p.frame_pulse_8k_out && !s_q.fp_prev;
    s_d.fp_prev = p.frame_pulse_8k_out;
    s_d.fsel = {p.freq_sel_high, p.freq_sel_low};
    s_d.ctl.corrector_realign = 1'b0;

    if (tick) begin
      case (ms)
        sync_mode_pkg::MS_FREE: go_free = 1'b1;
        sync_mode_pkg::MS_NORMAL: begin
          go_norm = 1'b1;
          tgt = p.ref_select_in;
        end
        sync_mode_pkg::MS_HOLD: begin
          if (s_q.st == ST_NORM && (p.ref_select_in || !s_q.ref_sec)) begin
            go_hold = 1'b1;
            tgt = p.ref_select_in;
          end
        end
        default: begin
          if (p.ref_select_in) begin
            evt[sync_mode_pkg::EVT_BAD_PINS] = 1'b1;
          end else if (p.primary_loss_in && p.secondary_loss_in) begin
            go_hold = s_q.st == ST_NORM;
          end else if (!p.primary_loss_in) begin
            go_norm = 1'b1;
            tgt = 1'b0;
          end else if (p.guard_time_in) begin
            go_norm = 1'b1;
            tgt = 1'b1;
          end else if (s_q.st == ST_FREE) begin
            go_norm = 1'b1;
            tgt = 1'b0;
          end else if (s_q.st == ST_NORM && !s_q.ref_sec) begin
            go_hold = 1'b1;
            tgt = 1'b0;
          end else if (s_q.st != ST_NORM && s_q.ref_sec) begin
            go_norm = 1'b1;
            tgt = 1'b1;
          end
        end
      endcase
      if ({p.freq_sel_high, p.freq_sel_low} == sync_mode_pkg::FS_RESERVED) begin
        evt[sync_mode_pkg::EVT_BAD_PINS] = 1'b1;
      end

      if (go_free) begin
        s_d.st = ST_FREE;
      end else if (s_q.st == ST_REALIGN) begin
        s_d.st = ST_NORM;
      end else if (s_q.st == ST_AUTO_HOLD && ms == sync_mode_pkg::MS_HOLD) begin
        s_d.st = ST_HOLD;
      end else if (go_hold) begin
        s_d.st = ST_HOLD;
        s_d.ref_sec = tgt;
      end else if (go_norm) begin
        if (s_q.st == ST_AUTO_HOLD && tgt == s_q.ref_sec) begin
          // Back to Normal with corrector untouched
          if (!p.ref_impaired || !s_q.mon_en) begin
            s_d.st = ST_NORM;
          end
        end else if (s_q.st == ST_NORM && tgt == s_q.ref_sec) begin
          s_d.st = ST_NORM;
        end else if (needs_align(s_q.st, s_q.ref_sec, tgt,
                                 p.guard_time_in)) begin
          // Holdover while the corrector realigns to the new input
          s_d.st = ST_REALIGN;
          s_d.ref_sec = tgt;
          s_d.corr_en = 1'b1;
        end else begin
          s_d.st = ST_NORM;
          s_d.ref_sec = tgt;
          s_d.corr_en = 1'b0;
        end
      end

      // Impaired input while staying in Normal forces auto-holdover
      if (s_q.st == ST_NORM && s_d.st == ST_NORM && s_q.mon_en &&
          p.ref_impaired) begin
        s_d.st = ST_AUTO_HOLD;
      end
    end

    // Loop controls follow the next state so they leave flops
    s_d.ctl.use_secondary_reference = s_d.ref_sec;
    s_d.ctl.phase_step_corrector_en = s_d.corr_en;
    s_d.ctl.corrector_realign = s_d.st == ST_REALIGN &&
                                s_q.st != ST_REALIGN;
    case (s_d.st)
      ST_FREE: s_d.ctl.mode = sync_mode_pkg::DPLL_FREERUN;
      ST_NORM: s_d.ctl.mode = sync_mode_pkg::DPLL_NORMAL;
      default: s_d.ctl.mode = sync_mode_pkg::DPLL_HOLDOVER;
    endcase
    hold_load = is_hold(s_d.st) && !is_hold(s_q.st);

    evt[sync_mode_pkg::EVT_CHANGE] = s_d.st != s_q.st;
    evt[sync_mode_pkg::EVT_AUTO_IN] = s_d.st == ST_AUTO_HOLD &&
                                      s_q.st != ST_AUTO_HOLD;
    evt[sync_mode_pkg::EVT_AUTO_OUT] = s_q.st == ST_AUTO_HOLD &&
                                       s_d.st == ST_NORM;

    // Lock watchdog from reset release
    if (!s_q.lock_done) begin
      if (dpll_locked) begin
        s_d.lock_done = 1'b1;
      end else if (s_q.lock_cnt == LCW'(LOCK_CYCLES - 1)) begin
        s_d.lock_done = 1'b1;
        evt[sync_mode_pkg::EVT_LOCK_LATE] = 1'b1;
      end else begin
        s_d.lock_cnt = s_q.lock_cnt + LCW'(1);
      end
    end

    // Register port; a new event beats a clear in the same cycle
    clr = '0;
    if (reg_wr) begin
      case (reg_addr)
        sync_mode_pkg::ADDR_CLEAR: clr = reg_wdata[EW-1:0];
        sync_mode_pkg::ADDR_ENABLE: s_d.enable = reg_wdata[EW-1:0];
        sync_mode_pkg::ADDR_CTRL: s_d.mon_en = reg_wdata[0];
        default: ;
      endcase
    end
    s_d.status = (s_q.status & ~clr) | evt;

    s_d.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        sync_mode_pkg::ADDR_STATUS: s_d.rdata[EW-1:0] = s_q.status;
        sync_mode_pkg::ADDR_ENABLE: s_d.rdata[EW-1:0] = s_q.enable;
        sync_mode_pkg::ADDR_CTRL: s_d.rdata[0] = s_q.mon_en;
        sync_mode_pkg::ADDR_STATE: begin
          s_d.rdata[sync_mode_pkg::STATE_FSM_POS +: 3] = s_q.st;
          s_d.rdata[sync_mode_pkg::STATE_SEC_POS] = s_q.ref_sec;
          s_d.rdata[sync_mode_pkg::STATE_CORR_POS] = s_q.corr_en;
          s_d.rdata[sync_mode_pkg::STATE_MODE_POS +: 2] = s_q.ctl.mode;
          s_d.rdata[sync_mode_pkg::STATE_FSEL_POS +: 2] = s_q.fsel;
          s_d.rdata[sync_mode_pkg::STATE_LOCK_POS] = dpll_locked;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.st <= ST_FREE;
      s_q.ctl.mode <= sync_mode_pkg::DPLL_FREERUN;
      s_q.enable <= sync_mode_pkg::ENABLE_RST;
      s_q.mon_en <= sync_mode_pkg::CTRL_MON_RST;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign loop_ctrl = s_q.ctl;
  assign freq_sel = s_q.fsel;
  assign irq = |(s_q.status & s_q.enable);

  a_step_on_frame: assert property (@(posedge core_clk) disable iff (!nrst)
    !(ce && tick) |=> $stable(s_q.st))
    else $error("state moved without a frame edge");

  a_auto_hold_entry: assert property (@(posedge core_clk) disable iff (!nrst)
    (ce && tick && s_q.st == ST_NORM && s_q.mon_en && p.ref_impaired &&
     ms == sync_mode_pkg::MS_AUTO && !p.ref_select_in && !p.primary_loss_in &&
     !s_q.ref_sec) |=> s_q.st == ST_AUTO_HOLD)
    else $error("impaired reference did not enter auto-holdover");

  a_auto_hold_exit: assert property (@(posedge core_clk) disable iff (!nrst)
    (ce && tick && s_q.st == ST_AUTO_HOLD && !p.ref_impaired &&
     ms == sync_mode_pkg::MS_AUTO && !p.ref_select_in && !p.primary_loss_in &&
     !s_q.ref_sec) |=> s_q.st == ST_NORM)
    else $error("auto-holdover did not return to normal");

  a_auto_no_corr: assert property (@(posedge core_clk) disable iff (!nrst)
    ($past(s_q.st) == ST_AUTO_HOLD && s_q.st == ST_NORM) |->
      $stable(s_q.corr_en) && !s_q.ctl.corrector_realign)
    else $error("auto-holdover exit touched the corrector");

  a_realign_then_norm: assert property (@(posedge core_clk) disable iff (!nrst)
    (ce && tick && s_q.st == ST_REALIGN && ms != sync_mode_pkg::MS_FREE) |=>
      s_q.st == ST_NORM && s_q.corr_en)
    else $error("realign did not finish in normal");

  a_guard_branch: assert property (@(posedge core_clk) disable iff (!nrst)
    (ce && tick && s_q.st == ST_NORM && !s_q.ref_sec &&
     ms == sync_mode_pkg::MS_AUTO && !p.ref_select_in && p.primary_loss_in &&
     !p.secondary_loss_in) |=>
      s_q.st == ($past(p.guard_time_in) ? ST_REALIGN : ST_HOLD))
    else $error("guard level picked the wrong branch");

  a_guard_corrector: assert property (@(posedge core_clk) disable iff (!nrst)
    (ce && tick && s_q.st == ST_HOLD && !s_q.ref_sec &&
     ms == sync_mode_pkg::MS_NORMAL && !p.ref_select_in) |=>
      s_q.corr_en == $past(p.guard_time_in))
    else $error("corrector enable does not follow guard level");

  a_manual_free: assert property (@(posedge core_clk) disable iff (!nrst)
    (ce && tick && ms == sync_mode_pkg::MS_FREE) |=> ##1
      loop_ctrl.mode == sync_mode_pkg::DPLL_FREERUN || !$past(ce))
    else $error("freerun select did not reach the loop");
endmodule : sync_mode_control_fsm
`default_nettype wire

// >>> verif/ctrl_side_model.sv
// Far-side model: control pin levels plus a free-running frame pulse.
// Assumes the bench changes pin levels well clear of a frame edge.
`timescale 1ns/1ps
`default_nettype none
module ctrl_side_model #(
  parameter int FRAME_CYCLES = 40
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire sync_mode_pkg::ctrl_pins_t levels,
  output var sync_mode_pkg::ctrl_pins_t pins
);
  logic [7:0] cnt_q;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 8'h00;
    end else if (cnt_q == 8'(FRAME_CYCLES - 1)) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // Frame pulse high for the first four cycles of each frame
  always_comb begin
    pins = levels;
    pins.frame_pulse_8k_out = (cnt_q < 8'h04);
  end
endmodule : ctrl_side_model
`default_nettype wire

// >>> verif/sync_mode_control_fsm_tb.sv
// Self-checking bench for the mode control block.
// Assumes short lock and store counts set through parameters.
`timescale 1ns/1ps
`default_nettype none
module sync_mode_control_fsm_tb;
  localparam logic [23:0] FREQ_A = 24'h123456;
  logic core_clk, nrst, ce, reg_wr, reg_rd, dpll_locked, irq, corr;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic [sync_mode_pkg::FREQ_W-1:0] dpll_freq, holdover_freq;
  logic [1:0] freq_sel;
  sync_mode_pkg::ctrl_pins_t lv, pins;
  sync_mode_pkg::loop_ctrl_t loop_ctrl;
  int n_fail, compares;

  ctrl_side_model #(.FRAME_CYCLES(40)) partner (.core_clk(core_clk),
    .nrst(nrst), .levels(lv), .pins(pins));

  sync_mode_control_fsm #(.LOCK_CYCLES(50), .STORE_CYCLES(8)) DUT (
    .core_clk(core_clk), .nrst(nrst), .ce(ce), .pins(pins),
    .dpll_locked(dpll_locked), .dpll_freq(dpll_freq),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .loop_ctrl(loop_ctrl),
    .freq_sel(freq_sel), .holdover_freq(holdover_freq), .irq(irq));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("Counts: compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_read

  // Returns just after the edge that raised the frame pulse pin
  task automatic wait_rise();
    int i;
    i = 0;
    while (i < 100 && pins.frame_pulse_8k_out) begin
      @(posedge core_clk);
      #1;
      i++;
    end
    while (i < 100 && !pins.frame_pulse_8k_out) begin
      @(posedge core_clk);
      #1;
      i++;
    end
    if (i == 100) begin
      check(32'h1, 32'h0);
      conclude();
    end
  endtask : wait_rise

  task automatic set_pins(input logic [1:0] ms, input logic rs, g, l1, l2,
                          input logic imp);
    @(posedge core_clk);
    lv <= {1'b0, imp, l1, l2, g, ms, rs, 2'h2};
  endtask : set_pins

  // Set pins, confirm nothing moves before the frame edge, then check
  task automatic step(input logic [1:0] ms, input logic rs, g, l1, l2,
                      input logic imp, input logic [2:0] fsm,
                      input logic sec, input logic [1:0] mode,
                      input logic [1:0] cr);
    logic [31:0] prev;
    logic [31:0] d;
    set_pins(ms, rs, g, l1, l2, imp);
    prev = 32'(loop_ctrl);
    repeat (8) @(posedge core_clk);
    #1;
    check(32'(loop_ctrl), prev);
    wait_rise();
    repeat (3) @(posedge core_clk);
    #1;
    check(32'(loop_ctrl.corrector_realign), 32'(fsm == 3'h4));
    repeat (3) @(posedge core_clk);
    #1;
    check(32'(loop_ctrl.use_secondary_reference), 32'(sec));
    check(32'(loop_ctrl.mode), 32'(mode));
    if (cr != 2'h2) begin
      check(32'(loop_ctrl.phase_step_corrector_en), 32'(cr[0]));
    end
    reg_read(sync_mode_pkg::ADDR_STATE, d);
    check({29'h0, d[2:0]}, {29'h0, fsm});
    check(32'({d[9:5], d[3]}), 32'({1'b1, 2'h2, mode, sec}));
  endtask : step

  initial begin
    n_fail = 0;
    compares = 0;
    nrst = 1'b0;
    ce = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    dpll_locked = 1'b0;
    dpll_freq = FREQ_A;
    lv = {8'h08, 2'h2};
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    #1;
    check(32'(loop_ctrl), 32'h2);
    check(32'(irq), 32'h0);
    reg_read(sync_mode_pkg::ADDR_ENABLE, rd);
    check(rd, 32'h0);
    @(posedge core_clk);
    #1;
    check(reg_rdata, 32'h0);
    reg_read(sync_mode_pkg::ADDR_CTRL, rd);
    check(rd, 32'h1);
    reg_write(8'h20, 32'hffff_ffff);
    reg_read(8'h20, rd);
    check(rd, 32'h0);
    repeat (60) @(posedge core_clk);
    reg_read(sync_mode_pkg::ADDR_STATUS, rd);
    check(32'(rd[sync_mode_pkg::EVT_LOCK_LATE]), 32'h1);
    check(32'(freq_sel), 32'h2);
    dpll_locked <= 1'b1;
    $display("Test reset done");
    step(2'h0, 0, 0, 0, 0, 0, 3'h1, 0, 2'h0, 2'h0);
    step(2'h1, 0, 0, 0, 0, 0, 3'h2, 0, 2'h1, 2'h2);
    step(2'h0, 0, 1, 0, 0, 0, 3'h4, 0, 2'h1, 2'h1);
    step(2'h0, 0, 1, 0, 0, 0, 3'h1, 0, 2'h0, 2'h1);
    step(2'h1, 0, 1, 0, 0, 0, 3'h2, 0, 2'h1, 2'h2);
    step(2'h0, 0, 0, 0, 0, 0, 3'h1, 0, 2'h0, 2'h0);
    step(2'h2, 0, 0, 0, 0, 0, 3'h0, 0, 2'h2, 2'h2);
    step(2'h0, 1, 0, 0, 0, 0, 3'h1, 1, 2'h0, 2'h2);
    step(2'h0, 0, 0, 0, 0, 0, 3'h4, 0, 2'h1, 2'h1);
    step(2'h0, 0, 0, 0, 0, 0, 3'h1, 0, 2'h0, 2'h2);
    $display("Test manual done");
    step(2'h3, 0, 0, 1, 0, 0, 3'h2, 0, 2'h1, 2'h2);
    step(2'h3, 0, 1, 0, 0, 0, 3'h4, 0, 2'h1, 2'h1);
    step(2'h3, 0, 1, 0, 0, 0, 3'h1, 0, 2'h0, 2'h1);
    step(2'h3, 0, 1, 1, 0, 0, 3'h4, 1, 2'h1, 2'h2);
    step(2'h3, 0, 1, 1, 0, 0, 3'h1, 1, 2'h0, 2'h2);
    step(2'h3, 0, 1, 1, 1, 0, 3'h2, 1, 2'h1, 2'h2);
    step(2'h3, 0, 0, 0, 0, 0, 3'h4, 0, 2'h1, 2'h2);
    step(2'h3, 0, 0, 0, 0, 0, 3'h1, 0, 2'h0, 2'h2);
    $display("Test auto done");
    reg_write(sync_mode_pkg::ADDR_CLEAR, 32'h1f);
    reg_write(sync_mode_pkg::ADDR_ENABLE, 32'h02);
    reg_read(sync_mode_pkg::ADDR_ENABLE, rd);
    check(rd, 32'h2);
    corr = loop_ctrl.phase_step_corrector_en;
    step(2'h3, 0, 0, 0, 0, 1, 3'h3, 0, 2'h1, 2'h2);
    check(32'(loop_ctrl.phase_step_corrector_en), 32'(corr));
    check(32'(irq), 32'h1);
    step(2'h3, 0, 0, 0, 0, 0, 3'h1, 0, 2'h0, 2'h2);
    check(32'(loop_ctrl.phase_step_corrector_en), 32'(corr));
    reg_read(sync_mode_pkg::ADDR_STATUS, rd);
    check(rd & 32'h6, 32'h6);
    reg_write(sync_mode_pkg::ADDR_CLEAR, 32'h2);
    #1;
    check(32'(irq), 32'h0);
    $display("Test auto-holdover done");
    step(2'h3, 1, 0, 0, 0, 0, 3'h1, 0, 2'h0, 2'h2);
    reg_read(sync_mode_pkg::ADDR_STATUS, rd);
    check(32'(rd[sync_mode_pkg::EVT_BAD_PINS]), 32'h1);
    $display("Test reserved done");
    // Newest slot gets the third word, older slot keeps the second
    wait_rise();
    set_pins(2'h3, 0, 0, 1, 0, 0);
    dpll_freq <= 24'h0f0f0f;
    repeat (33) @(posedge core_clk);
    dpll_freq <= 24'h654321;
    wait_rise();
    repeat (6) @(posedge core_clk);
    #1;
    check(32'(loop_ctrl.mode), 32'h1);
    check(32'(holdover_freq), 32'h0f0f0f);
    $display("Test holdover store done");
    // Clock enable low across a frame edge freezes the machine
    set_pins(2'h2, 0, 0, 0, 0, 0);
    ce <= 1'b0;
    repeat (50) @(posedge core_clk);
    #1;
    check(32'(loop_ctrl.mode), 32'h1);
    @(posedge core_clk);
    ce <= 1'b1;
    wait_rise();
    repeat (6) @(posedge core_clk);
    #1;
    check(32'(loop_ctrl.mode), 32'h2);
    $display("Test clock enable done");
    conclude();
  end
endmodule : sync_mode_control_fsm_tb
`default_nettype wire
